// >>> rtl/smsi_top.sv
// service pin override, operating mode tracking and status output
// assumes an AXI4-Lite master on mclk; mode events come from logic on
// mclk; service_n and host_tx_line are asynchronous pins
`timescale 1ns/100ps
module smsi_top
  import smsi_pkg::*;
#(
  parameter int MS_CYCLES = SMSI_MS_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // axi4-lite register port
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host pins
  input wire logic service_n,
  input wire logic host_tx_line,
  output logic stat,
  // primary serial port setting
  output logic [15:0] uart_div,
  output logic uart_data7,
  output logic uart_parity_en,
  output logic uart_parity_odd,
  output logic uart_two_stop,
  output logic cmd_set_active,
  // mode sources
  input wire logic rf_sync_found,
  input wire logic rf_frame_end,
  input wire logic tx_start,
  input wire logic tx_done,
  input wire logic tx_interval_tick,
  input wire logic cfg_session,
  input wire logic escape_cmd_en,
  input wire logic fault_event,
  input wire logic [7:0] fault_code_in,
  // mode effects
  output logic radio_en,
  output logic rxtx_block,
  output logic reboot_req,
  output logic wake_ok
);

  function automatic logic [16:0] ps_marg(input logic [15:0] t);
    ps_marg = 17'(t >> SMSI_PS_SHIFT) + 17'(SMSI_PS_MARG_MS);
  endfunction

  smsi_blink_if bl ();

  smsi_blink #(.MS_CYCLES(MS_CYCLES)) u_blink (
    .mclk(mclk),
    .arst_n(arst_n),
    .bl(bl.gen)
  );

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a level counts once stages two and three agree
  logic [2:0] svc_sync;
  logic [2:0] htx_sync;
  logic svc_n_f;
  logic htx_f;
  logic htx_prev;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      svc_sync <= 3'h7;
      htx_sync <= 3'h7;
      svc_n_f <= 1'b1;
      htx_f <= 1'b1;
      htx_prev <= 1'b1;
    end else begin
      svc_sync <= {svc_sync[1:0], service_n};
      htx_sync <= {htx_sync[1:0], host_tx_line};
      if (svc_sync[1] == svc_sync[2]) svc_n_f <= svc_sync[2];
      if (htx_sync[1] == htx_sync[2]) htx_f <= htx_sync[2];
      htx_prev <= htx_f;
    end
  end

  wire service_on = ~svc_n_f;
  wire htx_change = (htx_f != htx_prev);

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [31:0] ctrl;
  logic [7:0] fault_code;
  smsi_mode_t mode;
  smsi_mode_t next_mode;
  logic [12:0] flt_ms;
  logic [15:0] since_ms;
  logic [15:0] tmin;
  logic [15:0] ttx;
  logic [15:0] ps_left;
  logic [2:0] study;
  logic [6:0] ps_cyc;

  // axi write path
  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire do_wr = aw_held && w_held && !s_axi_bvalid;
  wire next_aw_held = (aw_held || aw_hs) && !do_wr;
  wire next_w_held = (w_held || w_hs) && !do_wr;
  wire wr_ctrl = do_wr && (wr_addr == SMSI_OFS_CTRL);
  wire wr_fault = do_wr && (wr_addr == SMSI_OFS_FAULT);
  wire wr_cmd = do_wr && (wr_addr == SMSI_OFS_CMD);
  wire wr_ok = (wr_addr == SMSI_OFS_CTRL) || (wr_addr == SMSI_OFS_FAULT)
               || (wr_addr == SMSI_OFS_CMD) || (wr_addr == SMSI_OFS_STATUS)
               || (wr_addr == SMSI_OFS_PSAVE);
  wire fault_clr = wr_fault && wr_strb[0] && wr_data[SMSI_FAULT_CLR];
  wire sleep_cmd = wr_cmd && wr_strb[0] && wr_data[SMSI_CMD_SLEEP];

  // mode events
  wire ms = bl.ms_tick;
  wire cmd_stored = ctrl[SMSI_CTRL_CMD_EN];
  wire ps_en = ctrl[SMSI_CTRL_PS_EN];
  wire study_ok = (study >= SMSI_PS_STUDY);
  wire [16:0] marg = ps_marg(tmin);
  wire [16:0] ps_need = marg + 17'(since_ms);
  wire ps_go = ps_en && study_ok && (17'(tmin) > ps_need);
  wire [15:0] ps_len = 16'(17'(tmin) - ps_need);
  wire slot_missed = ps_en && study_ok && (mode == SMSI_IDLE)
    && (17'(since_ms) > 17'(tmin) + marg + 17'(SMSI_PS_OVL_MS));
  wire rx_go = (mode == SMSI_IDLE) && !sleep_cmd && !tx_start
               && rf_sync_found;
  wire rx_end = (mode == SMSI_RX) && rf_frame_end;
  wire ps_wake = (mode == SMSI_PSLEEP) && (next_mode == SMSI_IDLE);
  wire reboot_now = (mode == SMSI_FAULT) && ms
                    && (flt_ms == 13'(SMSI_REBOOT_MS - 1));

  ////////////////////////////////////////////////////////////////////////
  // operating mode; the service pin takes no part here
  always_comb begin
    next_mode = mode;
    case (mode)
      SMSI_IDLE: begin
        if (sleep_cmd) next_mode = SMSI_SLEEP;
        else if (tx_start) next_mode = SMSI_TX;
        else if (rf_sync_found) next_mode = SMSI_RX;
      end
      SMSI_RX: begin
        if (rf_frame_end) next_mode = ps_go ? SMSI_PSLEEP : SMSI_IDLE;
      end
      SMSI_TX: begin
        if (tx_done) next_mode = SMSI_IDLE;
      end
      SMSI_SLEEP: begin
        if (htx_change) next_mode = SMSI_IDLE;
      end
      SMSI_PSLEEP: begin
        if (!ps_en || (ms && ps_left == 16'h0000)) next_mode = SMSI_IDLE;
      end
      SMSI_FAULT: begin
        if (reboot_now) next_mode = SMSI_SAFE;
      end
      SMSI_SAFE: begin
        if (fault_clr) next_mode = SMSI_IDLE;
      end
      default: next_mode = SMSI_IDLE;
    endcase
    // a new fault beats any other move, including a clear
    if (fault_event) next_mode = SMSI_FAULT;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= SMSI_IDLE;
      flt_ms <= '0;
      fault_code <= '0;
    end else begin
      mode <= next_mode;
      if (mode != SMSI_FAULT || fault_event) flt_ms <= '0;
      else if (ms) flt_ms <= flt_ms + 13'h0001;
      if (fault_event) fault_code <= fault_code_in;
      else if (fault_clr) fault_code <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power save study: shortest packet spacing and last frame length
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      since_ms <= '0;
      tmin <= '0;
      ttx <= '0;
      ps_left <= '0;
      study <= '0;
      ps_cyc <= '0;
    end else begin
      if (rx_go) since_ms <= '0;
      else if (ms && since_ms != 16'hFFFF) since_ms <= since_ms + 16'h0001;
      if (rx_go && study != 3'h0 && (study == 3'h1 || since_ms < tmin))
        tmin <= since_ms;
      if (rx_end) ttx <= since_ms;
      if (rx_end && ps_go) ps_left <= ps_len;
      else if (mode == SMSI_PSLEEP && ms && ps_left != 16'h0000)
        ps_left <= ps_left - 16'h0001;
      if (slot_missed || (ps_wake && ps_cyc == SMSI_PS_CYCLES - 7'h01)) begin
        study <= '0;
        ps_cyc <= '0;
      end else begin
        if (rx_go && study != 3'h7) study <= study + 3'h1;
        if (ps_wake) ps_cyc <= ps_cyc + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status pattern selection, highest priority first
  always_comb begin
    if (mode == SMSI_FAULT || mode == SMSI_SAFE) bl.pat = SMSI_PAT_B250;
    else if (cfg_session) bl.pat = SMSI_PAT_B1000;
    else if (escape_cmd_en && !cmd_stored) bl.pat = SMSI_PAT_B500;
    else if (mode == SMSI_TX) bl.pat = SMSI_PAT_TXTOG;
    else if (mode == SMSI_RX) bl.pat = SMSI_PAT_ZERO;
    else if (mode == SMSI_SLEEP || mode == SMSI_PSLEEP)
      bl.pat = SMSI_PAT_ZERO;
    else bl.pat = SMSI_PAT_ONE;
  end
  assign bl.tx_tick = tx_interval_tick;

  ////////////////////////////////////////////////////////////////////////
  // output flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stat <= 1'b1;
      uart_div <= SMSI_CTRL_RST[15:0];
      uart_data7 <= 1'b0;
      uart_parity_en <= 1'b0;
      uart_parity_odd <= 1'b0;
      uart_two_stop <= 1'b0;
      cmd_set_active <= SMSI_CTRL_RST[SMSI_CTRL_CMD_EN];
      radio_en <= 1'b1;
      rxtx_block <= 1'b0;
      reboot_req <= 1'b0;
      wake_ok <= 1'b0;
    end else begin
      stat <= bl.stat;
      // the stored word is only masked, never rewritten
      uart_div <= service_on ? SMSI_SVC_DIV : ctrl[15:0];
      uart_data7 <= !service_on && ctrl[SMSI_CTRL_DATA7];
      uart_parity_en <= !service_on && ctrl[SMSI_CTRL_PAR_EN];
      uart_parity_odd <= !service_on && ctrl[SMSI_CTRL_PAR_ODD];
      uart_two_stop <= !service_on && ctrl[SMSI_CTRL_TWO_STOP];
      cmd_set_active <= service_on || cmd_stored || escape_cmd_en;
      radio_en <= !(next_mode == SMSI_SLEEP || next_mode == SMSI_PSLEEP
                    || next_mode == SMSI_FAULT);
      rxtx_block <= (next_mode == SMSI_FAULT);
      reboot_req <= reboot_now;
      wake_ok <= (mode == SMSI_SLEEP) && htx_change && !fault_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SMSI_RESP_OKAY;
      ctrl <= SMSI_CTRL_RST;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (aw_hs) wr_addr <= {s_axi_awaddr[7:2], 2'b00};
      if (w_hs) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      s_axi_awready <= !next_aw_held && !(do_wr || s_axi_bvalid);
      s_axi_wready <= !next_w_held && !(do_wr || s_axi_bvalid);
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? SMSI_RESP_OKAY : SMSI_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        for (int b = 0; b < 4; b++) begin
          if (wr_strb[b]) ctrl[8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] status_word = {16'h0000, fault_code, radio_en, cmd_set_active,
                             service_on, stat, (mode == SMSI_SAFE), mode};
  wire rd_ctrl = (rd_addr == SMSI_OFS_CTRL);
  wire rd_stat = (rd_addr == SMSI_OFS_STATUS);
  wire rd_flt = (rd_addr == SMSI_OFS_FAULT);
  wire rd_ps = (rd_addr == SMSI_OFS_PSAVE);
  wire rd_ok = rd_ctrl || rd_stat || rd_flt || rd_ps
               || (rd_addr == SMSI_OFS_CMD);
  wire [31:0] rd_word = rd_ctrl ? ctrl
                      : rd_stat ? status_word
                      : rd_flt ? {24'h000000, fault_code}
                      : rd_ps ? {ttx, tmin}
                      : 32'h0000_0000;
  wire ar_hs = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SMSI_RESP_OKAY;
    end else begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? SMSI_RESP_OKAY : SMSI_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// >>> pkg/smsi_pkg.sv
// constants and types of the service mode and status indicator block
// assumes a 50 MHz mclk and a 32-bit AXI4-Lite register port
package smsi_pkg;

  // clock and time base
  localparam int SMSI_CLK_HZ = 50_000_000;
  localparam int SMSI_CLK_NS = 20;
  localparam int SMSI_MS_NS = 1_000_000;
  localparam int SMSI_MS_CYC = SMSI_MS_NS / SMSI_CLK_NS;

  // blink intervals and fault timing, in ms
  localparam int SMSI_FAULT_MS = 250;
  localparam int SMSI_ESC_MS = 500;
  localparam int SMSI_CFG_MS = 1000;
  localparam int SMSI_REBOOT_MS = 5000;

  // forced service setting of the primary serial port
  localparam int SMSI_SVC_BAUD = 38400;
  localparam logic [15:0] SMSI_SVC_DIV = 16'(SMSI_CLK_HZ / SMSI_SVC_BAUD);

  // power save study
  localparam logic [2:0] SMSI_PS_STUDY = 3'h4;
  localparam logic [6:0] SMSI_PS_CYCLES = 7'h64;
  localparam int SMSI_PS_MARG_MS = 60;
  localparam int SMSI_PS_OVL_MS = 100;
  localparam int SMSI_PS_SHIFT = 3;

  // register byte offsets
  localparam logic [7:0] SMSI_OFS_CTRL = 8'h00;
  localparam logic [7:0] SMSI_OFS_STATUS = 8'h04;
  localparam logic [7:0] SMSI_OFS_FAULT = 8'h08;
  localparam logic [7:0] SMSI_OFS_CMD = 8'h0C;
  localparam logic [7:0] SMSI_OFS_PSAVE = 8'h10;

  // ctrl fields: [15:0] stored baud divisor
  localparam int SMSI_CTRL_PAR_EN = 16;
  localparam int SMSI_CTRL_PAR_ODD = 17;
  localparam int SMSI_CTRL_TWO_STOP = 18;
  localparam int SMSI_CTRL_DATA7 = 19;
  localparam int SMSI_CTRL_CMD_EN = 20;
  localparam int SMSI_CTRL_PS_EN = 21;
  localparam logic [31:0] SMSI_CTRL_RST = 32'h0010_1458;

  // fault and cmd fields
  localparam int SMSI_FAULT_CLR = 0;
  localparam int SMSI_CMD_SLEEP = 0;

  localparam logic [1:0] SMSI_RESP_OKAY = 2'h0;
  localparam logic [1:0] SMSI_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SMSI_IDLE = 3'h0,
    SMSI_RX = 3'h1,
    SMSI_TX = 3'h3,
    SMSI_SLEEP = 3'h2,
    SMSI_PSLEEP = 3'h6,
    SMSI_FAULT = 3'h7,
    SMSI_SAFE = 3'h5
  } smsi_mode_t;

  typedef enum logic [2:0] {
    SMSI_PAT_ONE = 3'h0,
    SMSI_PAT_ZERO = 3'h1,
    SMSI_PAT_TXTOG = 3'h3,
    SMSI_PAT_B1000 = 3'h2,
    SMSI_PAT_B500 = 3'h6,
    SMSI_PAT_B250 = 3'h7
  } smsi_pat_t;

endpackage

// >>> pkg/smsi_blink_if.sv
// carrier between the mode logic and the status blink generator
// assumes both ends run on the same mclk
`timescale 1ns/100ps
interface smsi_blink_if;
  import smsi_pkg::*;
  smsi_pat_t pat;
  logic tx_tick;
  logic ms_tick;
  logic stat;
  modport ctrl (output pat, output tx_tick, input ms_tick, input stat);
  modport gen (input pat, input tx_tick, output ms_tick, output stat);
endinterface

// >>> rtl/smsi_blink.sv
// millisecond time base and status pattern generator
// assumes pat and tx_tick come from logic on mclk
`timescale 1ns/100ps
module smsi_blink
  import smsi_pkg::*;
#(
  parameter int MS_CYCLES = SMSI_MS_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // pattern in, time base and level out
  smsi_blink_if.gen bl
);

  localparam int PW = $clog2(MS_CYCLES);

  function automatic logic [9:0] half_ms(input smsi_pat_t p);
    case (p)
      SMSI_PAT_B250: half_ms = 10'(SMSI_FAULT_MS - 1);
      SMSI_PAT_B500: half_ms = 10'(SMSI_ESC_MS - 1);
      default: half_ms = 10'(SMSI_CFG_MS - 1);
    endcase
  endfunction

  logic [PW-1:0] pre;
  logic [9:0] phase;
  smsi_pat_t pat_q;

  wire pre_end = (pre == PW'(MS_CYCLES - 1));
  wire pat_chg = (bl.pat != pat_q);
  wire blinking = (bl.pat == SMSI_PAT_B250) || (bl.pat == SMSI_PAT_B500)
                  || (bl.pat == SMSI_PAT_B1000);
  wire phase_end = bl.ms_tick && (phase == half_ms(bl.pat));

  ////////////////////////////////////////////////////////////////////////
  // free-running time base, never restarted so every interval shares it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pre <= '0;
      bl.ms_tick <= 1'b0;
    end else begin
      pre <= pre_end ? '0 : pre + 1'b1;
      bl.ms_tick <= pre_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pat_q <= SMSI_PAT_ONE;
      phase <= '0;
      bl.stat <= 1'b1;
    end else begin
      pat_q <= bl.pat;
      if (pat_chg) begin
        // a new pattern starts with a fresh phase, high for every pattern but SMSI_PAT_ZERO
        phase <= '0;
        bl.stat <= (bl.pat != SMSI_PAT_ZERO);
      end else if (blinking) begin
        if (phase_end) begin
          phase <= '0;
          bl.stat <= ~bl.stat;
        end else if (bl.ms_tick) begin
          phase <= phase + 10'h001;
        end
      end else if (bl.pat == SMSI_PAT_TXTOG) begin
        if (bl.tx_tick) begin
          bl.stat <= ~bl.stat;
        end
      end else begin
        bl.stat <= (bl.pat == SMSI_PAT_ONE);
      end
    end
  end

endmodule

// >>> test/smsi_assertions.sv
// checker for the service override, fault timing and status level
// assumes it is bound into smsi_top and sees only its ports
`timescale 1ns/100ps
module smsi_assertions
  import smsi_pkg::*;
#(
  parameter int MS_CYCLES = SMSI_MS_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // pins and serial setting
  input wire logic service_n,
  input wire logic stat,
  input wire logic [15:0] uart_div,
  input wire logic uart_data7,
  input wire logic uart_parity_en,
  input wire logic uart_parity_odd,
  input wire logic uart_two_stop,
  input wire logic cmd_set_active,
  // mode sources and effects
  input wire logic cfg_session,
  input wire logic escape_cmd_en,
  input wire logic fault_event,
  input wire logic radio_en,
  input wire logic rxtx_block,
  input wire logic reboot_req,
  input wire logic wake_ok
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // the ms tick runs free, so reboot may land up to one ms early
  localparam int REB_LO = 4999 * MS_CYCLES;
  localparam int REB_HI = 5000 * MS_CYCLES + 8;
  logic [2:0] svc_low;
  int flt_cyc;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      svc_low <= 3'h0;
      flt_cyc <= 0;
    end else begin
      svc_low <= service_n ? 3'h0 : svc_low + {2'h0, svc_low != 3'h7};
      flt_cyc <= fault_event ? 0 : flt_cyc + 1;
    end
  end
  property p_svc_baud;
    svc_low == 3'h7 |-> uart_div == SMSI_SVC_DIV && !uart_data7 &&
      !uart_parity_en && !uart_parity_odd && !uart_two_stop;
  endproperty
  a_svc_baud: assert property (p_svc_baud)
    else $error("service setting not forced");
  property p_svc_cmd;
    svc_low == 3'h7 |-> cmd_set_active;
  endproperty
  a_svc_cmd: assert property (p_svc_cmd)
    else $error("commands not forced on");
  property p_fault_block;
    fault_event |-> ##[1:3] (rxtx_block && !radio_en);
  endproperty
  a_fault_block: assert property (p_fault_block)
    else $error("fault did not block traffic");
  property p_block_radio;
    rxtx_block |-> !radio_en;
  endproperty
  a_block_radio: assert property (p_block_radio)
    else $error("radio on while blocked");
  property p_reboot_time;
    reboot_req |-> flt_cyc >= REB_LO && flt_cyc <= REB_HI;
  endproperty
  a_reboot_time: assert property (p_reboot_time)
    else $error("reboot request at wrong time");
  property p_reboot_pulse;
    reboot_req |=> !reboot_req;
  endproperty
  a_reboot_pulse: assert property (p_reboot_pulse)
    else $error("reboot request too long");
  property p_sleep_zero;
    (!radio_en && !rxtx_block && !cfg_session && !escape_cmd_en)[*4]
      |-> !stat;
  endproperty
  a_sleep_zero: assert property (p_sleep_zero)
    else $error("status not low in sleep");
  property p_wake;
    wake_ok |-> ##[0:2] radio_en ##1 !wake_ok;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not restore radio");
endmodule
bind smsi_top smsi_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (.mclk,
  .arst_n, .service_n, .stat, .uart_div, .uart_data7, .uart_parity_en,
  .uart_parity_odd, .uart_two_stop, .cmd_set_active, .cfg_session,
  .escape_cmd_en, .fault_event, .radio_en, .rxtx_block, .reboot_req,
  .wake_ok);

// >>> test/smsi_host_model.sv
// host terminal: drives the service pin and the serial input line
// assumes mclk at 50 MHz; both pins idle high as with a pull-up
`timescale 1ns/100ps
module smsi_host_model (
  // clock
  input wire logic mclk,
  // pins toward the device
  output logic service_n,
  output logic host_tx_line,
  input wire logic stat
);
  // 600 cycles is 12 us, above the shortest wake pulse
  localparam int WAKE_CYC = 600;
  initial begin
    service_n = 1'b1;
    host_tx_line = 1'b1;
  end
  task automatic set_service(input logic lvl);
    @(posedge mclk);
    service_n <= lvl;
  endtask
  task automatic wake_pulse();
    @(posedge mclk);
    host_tx_line <= 1'b0;
    repeat (WAKE_CYC) @(posedge mclk);
    host_tx_line <= 1'b1;
  endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for smsi_top with a short ms time base
// assumes the host model drives service_n and host_tx_line
`timescale 1ns/100ps
module testbench;
  import smsi_pkg::*;
  localparam int MS = 4;
  logic mclk = 1'b0, arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, stat, uart_data7, uart_parity_en, uart_parity_odd;
  logic uart_two_stop, cmd_set_active, radio_en, rxtx_block, reboot_req;
  logic wake_ok;
  logic [15:0] uart_div;
  logic rf_sync_found = 1'b0, rf_frame_end = 1'b0, tx_start = 1'b0;
  logic tx_done = 1'b0, tx_interval_tick = 1'b0, cfg_session = 1'b0;
  logic escape_cmd_en = 1'b0, fault_event = 1'b0;
  logic [7:0] fault_code_in = 8'h00;
  wire service_n, host_tx_line;
  int error_cnt = 0, check_count = 0, wake_cnt = 0, n;
  time t0;
  smsi_top #(.MS_CYCLES(MS)) u_dut (.*);
  smsi_host_model u_host (.mclk, .service_n, .host_tx_line, .stat);
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (wake_ok === 1'b1) wake_cnt++;
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask
  task automatic tmo(input string what);
    error_cnt++;
    $display("MISMATCH %0t timeout %s", $time, what);
    complete_run();
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    rr = s_axi_bresp;
    if (n == 40) tmo("write");
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    {rd, rr} = {s_axi_rdata, s_axi_rresp};
    if (n == 40) tmo("read");
  endtask
  // skips the first, phase-restarted half period and times the next
  task automatic half(output int c);
    logic s;
    for (int k = 0; k < 2; k++) begin
      s = stat;
      for (c = 0; c < 2100 * MS && stat === s; c++) @(posedge mclk);
    end
    if (c >= 2100 * MS) tmo("blink");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    chk(stat, 1'b1, "idle stat");
    axi_rd(SMSI_OFS_CTRL);
    chk(rd, 32'h0010_1458, "ctrl reset");
    axi_rd(8'h40);
    chk(rr, 2'h2, "unmapped read");
    axi_wr(8'h40, 32'h0);
    chk(rr, 2'h2, "unmapped write");
    $display("test regs done");
  endtask
  task automatic t_service();
    int c;
    axi_wr(SMSI_OFS_CTRL, 32'h000B_0100);
    escape_cmd_en <= 1'b1;
    half(c);
    chk(c, 500 * MS, "escape blink");
    cfg_session <= 1'b1;
    half(c);
    chk(c, 1000 * MS, "session blink");
    {cfg_session, escape_cmd_en} <= 2'h0;
    u_host.set_service(1'b0);
    tick(8);
    chk(uart_div, 16'h0516, "svc div");
    chk({uart_data7, uart_parity_en, uart_parity_odd, uart_two_stop},
      4'h0, "svc frame");
    chk(cmd_set_active, 1'b1, "svc cmd");
    axi_rd(SMSI_OFS_CTRL);
    chk(rd, 32'h000B_0100, "ctrl kept");
    axi_rd(SMSI_OFS_STATUS);
    chk(rd[2:0], 3'h0, "mode kept");
    u_host.set_service(1'b1);
    tick(8);
    chk({uart_div, uart_data7, uart_parity_en, uart_parity_odd},
      19'h00807, "restored");
    chk(cmd_set_active, 1'b0, "cmd restored");
    axi_wr(SMSI_OFS_CTRL, 32'h0010_1458);
    $display("test service done");
  endtask
  task automatic t_rxtx();
    logic e;
    rf_frame_end <= 1'b1;
    tick(1);
    rf_frame_end <= 1'b0;
    tick(4);
    chk(stat, 1'b1, "no frame yet");
    rf_sync_found <= 1'b1;
    tick(1);
    rf_sync_found <= 1'b0;
    tick(40);
    chk(stat, 1'b0, "receiving");
    rf_frame_end <= 1'b1;
    tick(1);
    rf_frame_end <= 1'b0;
    tick(4);
    chk(stat, 1'b1, "frame over");
    tx_start <= 1'b1;
    tick(1);
    tx_start <= 1'b0;
    tick(4);
    e = 1'b1;
    for (int k = 0; k < 3; k++) begin
      tx_interval_tick <= 1'b1;
      tick(1);
      tx_interval_tick <= 1'b0;
      tick(4);
      e = ~e;
      chk(stat, e, "tx toggle");
    end
    tx_done <= 1'b1;
    tick(1);
    tx_done <= 1'b0;
    tick(4);
    chk(stat, 1'b1, "tx over");
    $display("test rx tx done");
  endtask
  task automatic t_sleep();
    axi_wr(SMSI_OFS_CMD, 32'h1);
    tick(4);
    chk(stat, 1'b0, "sleep stat");
    chk(radio_en, 1'b0, "sleep radio");
    u_host.wake_pulse();
    chk(wake_cnt, 32'h1, "wake answer");
    chk(radio_en, 1'b1, "awake radio");
    $display("test sleep done");
  endtask
  task automatic t_fault();
    int c;
    fault_code_in <= 8'h5A;
    fault_event <= 1'b1;
    t0 = $time;
    tick(1);
    fault_event <= 1'b0;
    tick(4);
    chk(rxtx_block, 1'b1, "blocked");
    half(c);
    chk(c, 250 * MS, "fault blink");
    axi_rd(SMSI_OFS_FAULT);
    chk(rd[7:0], 8'h5A, "fault code");
    for (c = 0; c < 5100 * MS && reboot_req !== 1'b1; c++) tick(1);
    if (c >= 5100 * MS) tmo("reboot");
    c = int'(($time - t0) / 20);
    chk(c >= 4999 * MS && c <= 5000 * MS + 10, 1'b1, "reboot");
    tick(4);
    axi_rd(SMSI_OFS_STATUS);
    chk({rd[3], rxtx_block}, 2'h2, "safe mode");
    axi_rd(SMSI_OFS_FAULT);
    chk(rd[7:0], 8'h5A, "safe code");
    axi_wr(SMSI_OFS_FAULT, 32'h1);
    tick(4);
    chk(stat, 1'b1, "cleared");
    $display("test fault done");
  endtask
  // frames 200 ms apart, 10 ms long: the study ends on the third sync, as t_rxtx already counted one
  task automatic t_psave();
    axi_wr(SMSI_OFS_CTRL, 32'h0030_1458);
    for (int k = 0; k < 4; k++) begin
      rf_sync_found <= 1'b1;
      tick(1);
      rf_sync_found <= 1'b0;
      tick(10 * MS);
      rf_frame_end <= 1'b1;
      tick(1);
      rf_frame_end <= 1'b0;
      tick(k == 3 ? 4 : 190 * MS);
    end
    chk({radio_en, stat}, 2'h0, "ps sleep");
    tick(120 * MS);
    chk(radio_en, 1'b1, "ps wake");
    $display("test power save done");
  endtask
  initial begin
    tick(2);
    arst_n <= 1'b1;
    t_regs();
    t_service();
    t_rxtx();
    t_sleep();
    t_fault();
    t_psave();
    complete_run();
  end
endmodule
